// ### design/uei_top.sv
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "uei_defines.svh"
module uei_top (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,

	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`UEI_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,

	// link status levels
	input wire logic i_vbus_valid,
	input wire logic i_session_active,

	// link event pulses
	input wire logic i_session_request,
	input wire logic i_peripheral_connect,
	input wire logic i_peripheral_disconnect,
	input wire logic i_frame_start,
	input wire logic i_bus_reset,
	input wire logic i_babble,
	input wire logic i_wakeup_signal,
	input wire logic i_sleep_signal,

	// endpoint receive completion pulses
	input wire logic [`UEI_EP_MSB:`UEI_EP_LSB] i_ep_rx_done,

	// interrupt and mode
	output logic o_usb_irq,
	output logic o_host_mode,
	output logic [`UEI_EP_MSB:`UEI_EP_LSB] o_ep_rx_irq_en
);
	import uei_pkg::*;

	// ----------------------------------------
	// state and flag banks
	// ----------------------------------------
	uei_regs_t st_q;
	uei_regs_t st_d;

	uei_flag_if #(.W(8)) evt_if ();
	uei_flag_if #(.W(7)) ep_if ();

	uei_sticky_flags #(.W(8)) u_evt_flags (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.bus(evt_if.owner)
	);

	uei_sticky_flags #(.W(7)) u_ep_flags (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.bus(ep_if.owner)
	);

	// ----------------------------------------
	// link event detection
	// ----------------------------------------
	logic supply_drop;
	logic session_end;
	logic [7:0] evt_set;

	// edges rather than levels, so a read clear is not undone at once
	// while the supply stays low
	assign supply_drop = st_q.vbus_valid & ~i_vbus_valid & i_session_active;
	assign session_end = st_q.session & ~i_session_active;

	always_comb begin
		evt_set = 8'h00;
		evt_set[`UEI_F_SUPPLY] = supply_drop;
		evt_set[`UEI_F_SESSION] = i_session_request;
		if (st_q.host_mode) begin
			evt_set[`UEI_F_DISC] = i_peripheral_disconnect;
			evt_set[`UEI_F_CONN] = i_peripheral_connect;
			evt_set[`UEI_F_RST] = i_babble;
		end else begin
			evt_set[`UEI_F_DISC] = session_end;
			evt_set[`UEI_F_CONN] = 1'b0;
			evt_set[`UEI_F_RST] = i_bus_reset;
		end
		evt_set[`UEI_F_SOF] = i_frame_start;
		evt_set[`UEI_F_WAKE] = i_wakeup_signal;
		evt_set[`UEI_F_SLEEP] = i_sleep_signal;
	end

	assign evt_if.set = evt_set;
	assign ep_if.set = i_ep_rx_done;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic access;
	logic hit_evt;
	logic hit_ver;
	logic hit_cfg;
	logic hit_epst;
	logic hit_any;
	logic [31:0] wmask;

	assign access = i_psel & i_penable;
	assign hit_evt = (i_paddr == `UEI_OFS_EVT);
	assign hit_ver = (i_paddr == `UEI_OFS_VER);
	assign hit_cfg = (i_paddr == `UEI_OFS_CFG);
	assign hit_epst = (i_paddr == `UEI_OFS_EPST);
	assign hit_any = hit_evt | hit_ver | hit_cfg | hit_epst;
	assign wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
		{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [31:0] rd_word;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_evt) begin
			rd_word[`UEI_EN_MSB:`UEI_EN_LSB] = st_q.en;
			rd_word[`UEI_FL_MSB:`UEI_FL_LSB] = evt_if.flags;
			rd_word[`UEI_EP_MSB:`UEI_EP_LSB] = st_q.ep_en;
		end else if (hit_ver) begin
			rd_word[`UEI_VER_RC_BIT] = `UEI_VER_RC;
			rd_word[`UEI_VER_MAJ_MSB:`UEI_VER_MAJ_LSB] =
				`UEI_VER_MAJOR;
			rd_word[`UEI_VER_MIN_MSB:`UEI_VER_MIN_LSB] =
				`UEI_VER_MINOR;
		end else if (hit_cfg) begin
			rd_word[`UEI_CFG_HOST] = st_q.host_mode;
		end else if (hit_epst) begin
			rd_word[`UEI_EP_MSB:`UEI_EP_LSB] = ep_if.flags;
		end
	end

	// ----------------------------------------
	// write merge
	// ----------------------------------------
	logic [31:0] evt_old;
	logic [31:0] evt_new;
	logic [31:0] cfg_new;

	assign evt_old = {st_q.en, 16'h0000, st_q.ep_en, 1'b0};
	assign evt_new = (evt_old & ~wmask) | (i_pwdata & wmask);
	assign cfg_new = ({31'h0, st_q.host_mode} & ~wmask) |
		(i_pwdata & wmask);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// one wait state: the answer is computed in the first access cycle
	// and registered, so bus outputs come straight from flip-flops
	always_comb begin
		st_d = st_q;
		st_d.vbus_valid = i_vbus_valid;
		st_d.session = i_session_active;
		st_d.pready = 1'b0;
		evt_if.clr = 8'h00;
		ep_if.clr = 7'h00;
		case (st_q.state)
			UEI_ST_IDLE: begin
				if (access) begin
					st_d.state = UEI_ST_RESP;
					st_d.pready = 1'b1;
					st_d.pslverr = ~hit_any;
					st_d.prdata = i_pwrite ? 32'h0000_0000 : rd_word;
					// remember exactly what was reported; only those
					// bits are cleared when the transfer completes
					st_d.rd_evt = (~i_pwrite & hit_evt) ?
						evt_if.flags : 8'h00;
					st_d.rd_ep = (~i_pwrite & hit_epst) ?
						ep_if.flags : 7'h00;
				end
			end
			UEI_ST_RESP: begin
				st_d.state = UEI_ST_IDLE;
				st_d.pslverr = 1'b0;
				if (access) begin
					evt_if.clr = st_q.rd_evt;
					ep_if.clr = st_q.rd_ep;
					if (i_pwrite & hit_evt) begin
						st_d.en =
							evt_new[`UEI_EN_MSB:`UEI_EN_LSB];
						st_d.ep_en =
							evt_new[`UEI_EP_MSB:`UEI_EP_LSB];
					end
					if (i_pwrite & hit_cfg) begin
						st_d.host_mode = cfg_new[`UEI_CFG_HOST];
					end
				end
				st_d.rd_evt = 8'h00;
				st_d.rd_ep = 7'h00;
			end
			default: begin
				st_d.state = UEI_ST_IDLE;
				st_d.pslverr = 1'b0;
			end
		endcase
		// frame start, wakeup and sleep need their enables like the rest
		st_d.irq = (|(evt_if.flags & st_q.en)) |
			(|(ep_if.flags & st_q.ep_en));
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q.state <= UEI_ST_IDLE;
			st_q.en <= `UEI_EN_RST;
			st_q.ep_en <= `UEI_EP_RST;
			st_q.host_mode <= 1'b0;
			st_q.vbus_valid <= 1'b0;
			st_q.session <= 1'b0;
			st_q.pready <= 1'b0;
			st_q.pslverr <= 1'b0;
			st_q.prdata <= 32'h0000_0000;
			st_q.rd_evt <= 8'h00;
			st_q.rd_ep <= 7'h00;
			st_q.irq <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_prdata = st_q.prdata;
	assign o_pready = st_q.pready;
	assign o_pslverr = st_q.pslverr;
	assign o_usb_irq = st_q.irq;
	assign o_host_mode = st_q.host_mode;
	assign o_ep_rx_irq_en = st_q.ep_en;
endmodule

// ### design/uei_defines.svh
// How it works
// - supply error flag, bit 23, sets when supply drops during a live session
// - session request flag, bit 22, sets on partner session request
// - disconnect flag, bit 21: peripheral leaves (host) or session ends (device)
// - connect flag, bit 20, sets in host mode when a peripheral attaches
// - bits 31:24 are read/write enables for the eight link events
// - reset/babble enable, bit 26, covers reset or babble; resets to one
// - frame start, wakeup and sleep events interrupt only while enabled
// - flag bits 23:16 are read-only, hardware set, zero after reset
// - bits 7:1 are endpoint receive enables, reset to one; bit 0 absent
// - unimplemented bits ignore writes and read as zero
// - version bit 15 shows a prerelease build
// - version bits 14:10 hold the read-only major revision
// - version bits 9:0 hold the minor revision; writes do nothing
`ifndef UEI_DEFINES_SVH
`define UEI_DEFINES_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define UEI_ADDR_W 12
`define UEI_OFS_EVT 12'h000
`define UEI_OFS_VER 12'h004
`define UEI_OFS_CFG 12'h008
`define UEI_OFS_EPST 12'h00c

// ----------------------------------------
// field positions
// ----------------------------------------
`define UEI_EN_MSB 31
`define UEI_EN_LSB 24
`define UEI_FL_MSB 23
`define UEI_FL_LSB 16
`define UEI_EP_MSB 7
`define UEI_EP_LSB 1
`define UEI_F_SUPPLY 7
`define UEI_F_SESSION 6
`define UEI_F_DISC 5
`define UEI_F_CONN 4
`define UEI_F_SOF 3
`define UEI_F_RST 2
`define UEI_F_WAKE 1
`define UEI_F_SLEEP 0
`define UEI_CFG_HOST 0
`define UEI_VER_RC_BIT 15
`define UEI_VER_MAJ_MSB 14
`define UEI_VER_MAJ_LSB 10
`define UEI_VER_MIN_MSB 9
`define UEI_VER_MIN_LSB 0

// ----------------------------------------
// reset and fixed values
// ----------------------------------------
`define UEI_EN_RST 8'h06
`define UEI_EP_RST 7'h7f
`define UEI_VER_RC 1'h0
`define UEI_VER_MAJOR 5'h02
`define UEI_VER_MINOR 10'h000

`endif

// ### design/uei_pkg.sv
package uei_pkg;

	// ----------------------------------------
	// bus slave states
	// ----------------------------------------
	typedef enum logic [1:0] {
		UEI_ST_IDLE = 2'b01,
		UEI_ST_RESP = 2'b10
	} uei_state_t;

	// ----------------------------------------
	// all state of the top module
	// ----------------------------------------
	typedef struct packed {
		uei_state_t state;
		logic [7:0] en;
		logic [6:0] ep_en;
		logic host_mode;
		logic vbus_valid;
		logic session;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [7:0] rd_evt;
		logic [6:0] rd_ep;
		logic irq;
	} uei_regs_t;

endpackage

// ### design/uei_flag_if.sv
`timescale 1ns/100ps
interface uei_flag_if #(
	parameter int W = 8
);
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic [W-1:0] flags;

	modport owner (
		input set,
		input clr,
		output flags
	);
	modport user (
		output set,
		output clr,
		input flags
	);
endinterface

// ### design/uei_sticky_flags.sv
`timescale 1ns/100ps
module uei_sticky_flags #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// flag port
	uei_flag_if.owner bus
);
	typedef struct packed {
		logic [W-1:0] flags;
	} uei_flag_state_t;

	uei_flag_state_t st_q;
	uei_flag_state_t st_d;

	// a set in the clearing cycle survives: set is applied last
	always_comb begin
		st_d = st_q;
		st_d.flags = (st_q.flags & ~bus.clr) | bus.set;
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.flags = st_q.flags;
endmodule

// ### tb/uei_link_partner.sv
`timescale 1ns/100ps
module uei_link_partner (
	// bench control
	input wire logic i_ref_clk,
	input wire logic i_go,
	input wire logic [3:0] i_cmd,
	// link side
	output logic [7:0] o_ev,
	output logic o_vbus_valid,
	output logic o_session_active
);
	initial begin
		o_ev = 8'h00;
		o_vbus_valid = 1'h0;
		o_session_active = 1'h0;
	end
	// -----------------------------
	// cmd 0..7 pulse one event line for exactly one clock;
	// 8 drops supply, 9 ends session, 10 starts a session
	// -----------------------------
	always @(posedge i_ref_clk) begin
		o_ev <= 8'h00;
		if (i_go && i_cmd < 4'h8) begin
			o_ev <= 8'h01 << i_cmd;
		end
		if (i_go && i_cmd == 4'h8) begin
			o_vbus_valid <= 1'h0;
		end
		if (i_go && i_cmd == 4'h9) begin
			o_session_active <= 1'h0;
		end
		if (i_go && i_cmd == 4'ha) begin
			o_vbus_valid <= 1'h1;
			o_session_active <= 1'h1;
		end
	end
endmodule

// ### tb/uei_top_props.sv
`timescale 1ns/100ps
`include "uei_defines.svh"
module uei_top_props (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// bus
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`UEI_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// link
	input wire logic [7:1] i_ep_rx_done,
	input wire logic o_usb_irq,
	input wire logic [7:1] o_ep_rx_irq_en
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	wire rd = o_pready && !i_pwrite;
	wire wr_evt = o_pready && i_pwrite && i_paddr == `UEI_OFS_EVT;
	sequence s_setup_acc;
		i_psel && !i_penable ##1 i_psel && i_penable;
	endsequence
	a_ready_timing: assert property (s_setup_acc |=> o_pready)
		else $error("pready not one cycle after access");
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_ver_value: assert property (
		rd && i_paddr == `UEI_OFS_VER |-> o_prdata == 32'h00000800)
		else $error("version value wrong");
	a_evt_reserved: assert property (
		rd && i_paddr == `UEI_OFS_EVT |-> o_prdata[15:8] == 8'h00
		&& !o_prdata[0])
		else $error("reserved status bits not zero");
	a_unmapped_err: assert property (
		o_pready && i_paddr > `UEI_OFS_EPST |-> o_pslverr
		&& o_prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (o_pready && i_paddr[1:0] == 2'h0
		&& i_paddr <= `UEI_OFS_EPST |-> !o_pslverr)
		else $error("mapped access refused");
	a_ep_irq: assert property (
		(i_ep_rx_done & o_ep_rx_irq_en) != 7'h00 |-> ##2 o_usb_irq)
		else $error("endpoint event gave no irq");
	a_ep_en_write: assert property (
		$changed(o_ep_rx_irq_en) |-> $past(wr_evt) || $past(wr_evt, 2))
		else $error("endpoint enables changed without write");
endmodule
bind uei_top uei_top_props u_uei_top_props (.i_ref_clk, .i_sys_rst,
	.i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready,
	.o_pslverr, .i_ep_rx_done, .o_usb_irq, .o_ep_rx_irq_en);

// ### tb/uei_top_bench.sv
`timescale 1ns/100ps
`include "uei_defines.svh"
module uei_top_bench;
	logic i_ref_clk = 1'h0;
	logic i_sys_rst = 1'h1;
	logic i_psel = 1'h0;
	logic i_penable = 1'h0;
	logic i_pwrite = 1'h0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0;
	logic [7:1] ep_done = 7'h00;
	logic go = 1'h0;
	logic [3:0] cmd = 4'h0;
	logic [7:0] ev;
	logic vb, ss, o_pready, o_pslverr, o_usb_irq, o_host_mode;
	logic [31:0] o_prdata, rd;
	logic [7:1] ep_en;
	logic err;
	logic hm;
	logic [7:0] fl;
	logic [31:0] ew;
	int mismatches = 0;
	int n_tests = 0;
	// row layout: host mode bit, partner command, expected flag byte
	logic [12:0] tbl [15] = '{13'h1a00, 13'h1880, 13'h1040, 13'h1110,
		13'h1220, 13'h1308, 13'h1400, 13'h1504, 13'h1602, 13'h1701,
		13'h0100, 13'h0200, 13'h0404, 13'h0500, 13'h0920};
	always #50 i_ref_clk = ~i_ref_clk;
	uei_top u_uei_top (.i_ref_clk, .i_sys_rst, .i_psel, .i_penable,
		.i_pwrite, .i_paddr, .i_pwdata, .i_pstrb(4'hf), .o_prdata,
		.o_pready, .o_pslverr, .i_vbus_valid(vb), .i_session_active(ss),
		.i_session_request(ev[0]), .i_peripheral_connect(ev[1]),
		.i_peripheral_disconnect(ev[2]), .i_frame_start(ev[3]),
		.i_bus_reset(ev[4]), .i_babble(ev[5]), .i_wakeup_signal(ev[6]),
		.i_sleep_signal(ev[7]), .i_ep_rx_done(ep_done), .o_usb_irq,
		.o_host_mode, .o_ep_rx_irq_en(ep_en));
	uei_link_partner u_uei_link_partner (.i_ref_clk, .i_go(go),
		.i_cmd(cmd), .o_ev(ev), .o_vbus_valid(vb), .o_session_active(ss));
	task chk(input string nm, input logic [31:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask
	// the request stands until pready is seen high at a rising edge;
	// data and error are taken at that edge, then the outputs settle
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_ref_clk);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'h1;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (o_pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			$display("mismatch pready exp 1 got 0");
		end
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		@(negedge i_ref_clk);
	endtask
	task link(input logic [3:0] c);
		@(posedge i_ref_clk);
		cmd <= c;
		go <= 1'h1;
		@(posedge i_ref_clk);
		go <= 1'h0;
		repeat (4) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask
	task pep(input logic [7:1] v);
		@(posedge i_ref_clk);
		ep_done <= v;
		@(posedge i_ref_clk);
		ep_done <= 7'h00;
		repeat (4) @(negedge i_ref_clk);
	endtask
	task close_out;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		$display("mismatch watchdog exp done got timeout");
		close_out();
	end
	initial begin
		repeat (4) @(posedge i_ref_clk);
		i_sys_rst <= 1'h0;
		apb(1'h0, `UEI_OFS_EVT, 32'h0);
		chk("evt_rst", 32'h060000fe, rd);
		chk("irq_rst", 32'h0, {31'h0, o_usb_irq});
		chk("host_rst", 32'h0, {31'h0, o_host_mode});
		apb(1'h0, `UEI_OFS_VER, 32'h0);
		chk("ver", 32'h00000800, rd);
		apb(1'h1, `UEI_OFS_VER, 32'hffffffff);
		apb(1'h0, `UEI_OFS_VER, 32'h0);
		chk("ver_wr", 32'h00000800, rd);
		apb(1'h1, `UEI_OFS_EVT, 32'hffffffff);
		apb(1'h0, `UEI_OFS_EVT, 32'h0);
		chk("evt_wr", 32'hff0000fe, rd);
		apb(1'h0, 12'h010, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		for (int i = 0; i < 15; i++) begin
			hm = tbl[i][12];
			fl = tbl[i][7:0];
			ew = {8'hff, fl, 16'h00fe};
			apb(1'h1, `UEI_OFS_CFG, {31'h0, hm});
			chk("host", {31'h0, hm}, {31'h0, o_host_mode});
			link(tbl[i][11:8]);
			chk("irq", {31'h0, |fl}, {31'h0, o_usb_irq});
			apb(1'h0, `UEI_OFS_EVT, 32'h0);
			chk("flags", ew, rd);
			apb(1'h0, `UEI_OFS_EVT, 32'h0);
			chk("cleared", 32'hff0000fe, rd);
		end
		apb(1'h1, `UEI_OFS_EVT, 32'hf7000000);
		chk("ep_off", 32'h0, {25'h0, ep_en});
		link(4'h3);
		chk("sof_masked", 32'h0, {31'h0, o_usb_irq});
		apb(1'h0, `UEI_OFS_EVT, 32'h0);
		chk("sof_flag", 32'hf7080000, rd);
		pep(7'h01);
		chk("ep_masked", 32'h0, {31'h0, o_usb_irq});
		apb(1'h0, `UEI_OFS_EPST, 32'h0);
		chk("ep1_flag", 32'h00000002, rd);
		apb(1'h1, `UEI_OFS_EVT, 32'h000000fe);
		chk("ep_idle", 32'h0, {31'h0, o_usb_irq});
		pep(7'h40);
		chk("ep_irq", 32'h1, {31'h0, o_usb_irq});
		apb(1'h0, `UEI_OFS_EPST, 32'h0);
		chk("epst", 32'h00000080, rd);
		repeat (3) @(negedge i_ref_clk);
		chk("ep_clr", 32'h0, {31'h0, o_usb_irq});
		close_out();
	end
endmodule
